//--- scp_pkg.sv
// constants and types shared by the serial command port
//
// Behaviour
// - Every character is one start bit, seven data bits, odd parity and one stop bit at 300 baud both ways.
// - The port is half duplex, so no response starts while a command line is being received.
// - Line feed ends a command line, and every response ends with a line feed.
// - Arguments are taken without leading or fractional zeros, while responses carry the padded text.
// - A numeric argument may hold its decimal point anywhere among its digits or none at all.
// - Temperatures are kept to a tenth of a degree and further digits are truncated.
// - Accepted temperatures are limited to the range 0 to 475 kelvin.
// - Every function may be commanded remotely except calibration point entry, which is refused.
// - Only W queries get a response, and the host reads only after a query.
package scp_pkg;
   localparam int CLK_HZ     = 50_000_000;
   localparam int BAUD       = 300;
   localparam int OVS        = 16;
   localparam int TICK_DIV   = CLK_HZ / (BAUD * OVS);
   localparam int CHAR_W     = 7;
   localparam int FRAME_BITS = 10;
   localparam logic [3:0] OVS_LAST = 4'hF;
   localparam logic [3:0] OVS_MID  = 4'h7;
   localparam logic [3:0] BIT_LAST = 4'h9;
   localparam logic [6:0] CH_LF    = 7'h0A;
   localparam logic [6:0] CH_CR    = 7'h0D;
   localparam logic [6:0] CH_DOT   = 7'h2E;
   localparam logic [6:0] CH_MINUS = 7'h2D;
   localparam logic [6:0] CH_QUERY = 7'h57;
   localparam logic [6:0] CH_NONE  = 7'h00;
   localparam logic [9:0] INT_MAX  = 10'h1DB;
   localparam logic [9:0] INT_SAT  = 10'h3E8;
   localparam logic [12:0] TENTHS_MAX = 13'h128E;
   localparam logic [1:0] ARG_NONE = 2'h0;
   localparam logic [1:0] ARG_INT  = 2'h1;
   localparam logic [1:0] ARG_FRAC = 2'h2;
   localparam logic [1:0] ARG_DONE = 2'h3;
   typedef enum logic { SCP_RX_IDLE, SCP_RX_BITS } scp_rx_t;
   typedef enum logic [1:0] { SCP_TX_IDLE, SCP_TX_BITS, SCP_TX_LF }
      scp_tx_t;
endpackage

//--- scp_fifo.sv
// response character fifo, flop storage
`timescale 1ns/1ps
module scp_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         srst,
   // fill side
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // drain side
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0]   cnt_reg;
   logic          full_reg;
   logic          empty_reg;
   logic          push;
   logic          pop;

   assign push      = in_valid && !full_reg;
   assign pop       = out_ready && !empty_reg;
   assign in_ready  = !full_reg;
   assign out_valid = !empty_reg;
   assign out_data  = mem[rd_reg];

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_reg] <= in_data;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wr_reg    <= '0;
         rd_reg    <= '0;
         cnt_reg   <= '0;
         full_reg  <= 1'b0;
         empty_reg <= 1'b1;
      end
      else
      begin
         if (push)
            wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
         if (pop)
            rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
         if (push && !pop)
         begin
            cnt_reg   <= cnt_reg + 1'b1;
            full_reg  <= (cnt_reg == (AW+1)'(DEPTH - 1));
            empty_reg <= 1'b0;
         end
         else if (pop && !push)
         begin
            cnt_reg   <= cnt_reg - 1'b1;
            full_reg  <= 1'b0;
            empty_reg <= (cnt_reg == (AW+1)'(1));
         end
      end
   end
endmodule

//--- scp_top.sv
// serial command port: 7O1 receiver, line parser, response transmitter
`timescale 1ns/1ps
module scp_top
   import scp_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_DIV,
   parameter int RESP_DEPTH  = 16,
   parameter logic [6:0] CAL_CMD = 7'h43
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // serial link
   input  wire logic        rxd,
   output logic             txd,
   // decoded command
   output logic             cmd_valid,
   output logic [6:0]       cmd_op0,
   output logic [6:0]       cmd_op1,
   output logic [6:0]       cmd_opt,
   output logic             cmd_has_arg,
   output logic [12:0]      cmd_arg,
   output logic             cmd_query,
   output logic             cmd_refused,
   output logic             rx_err,
   // response text
   input  wire logic        resp_valid,
   input  wire logic [6:0]  resp_data,
   input  wire logic        resp_last,
   output logic             resp_ready
);
   function automatic logic odd_par(input logic [6:0] d);
      return ~^d;
   endfunction

   function automatic logic is_digit(input logic [6:0] c);
      return (c >= 7'h30) && (c <= 7'h39);
   endfunction

   // oversampling tick
   logic [13:0] div_reg;
   logic        tick_reg;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         div_reg  <= '0;
         tick_reg <= 1'b0;
      end
      else if (div_reg == 14'(TICK_CYCLES - 1))
      begin
         div_reg  <= '0;
         tick_reg <= 1'b1;
      end
      else
      begin
         div_reg  <= div_reg + 1'b1;
         tick_reg <= 1'b0;
      end
   end

   // receiver
   scp_rx_t     rx_st_reg;
   logic        rxd_prev_reg;
   logic [3:0]  rx_ovs_reg;
   logic [3:0]  rx_bit_reg;
   logic [9:0]  rx_sh_reg;
   logic        rx_done_reg;
   logic        rx_bad_reg;
   logic        rx_sample;

   assign rx_sample = tick_reg && (rx_ovs_reg == OVS_MID);

   always_ff @(posedge clk)
   begin
      if (srst)
         rxd_prev_reg <= 1'b1;
      else
         rxd_prev_reg <= rxd;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rx_st_reg   <= SCP_RX_IDLE;
         rx_ovs_reg  <= '0;
         rx_bit_reg  <= '0;
         rx_sh_reg   <= '0;
         rx_done_reg <= 1'b0;
         rx_bad_reg  <= 1'b0;
      end
      else
      begin
         rx_done_reg <= 1'b0;
         case (rx_st_reg)
            SCP_RX_IDLE:
            begin
               if (rxd_prev_reg && !rxd)
               begin
                  rx_st_reg  <= SCP_RX_BITS;
                  rx_ovs_reg <= '0;
                  rx_bit_reg <= '0;
               end
            end
            SCP_RX_BITS:
            begin
               if (tick_reg)
                  rx_ovs_reg <= rx_ovs_reg + 1'b1;
               if (rx_sample)
               begin
                  rx_sh_reg  <= {rxd, rx_sh_reg[9:1]};
                  rx_bit_reg <= rx_bit_reg + 1'b1;
                  // a glitch that is high mid-start is not a frame
                  if (rx_bit_reg == 4'h0 && rxd)
                     rx_st_reg <= SCP_RX_IDLE;
                  if (rx_bit_reg == BIT_LAST)
                  begin
                     rx_st_reg   <= SCP_RX_IDLE;
                     rx_done_reg <= 1'b1;
                     rx_bad_reg  <= !rxd ||
                        (odd_par(rx_sh_reg[8:2]) != rx_sh_reg[9]);
                  end
               end
            end
            default:
               rx_st_reg <= SCP_RX_IDLE;
         endcase
      end
   end

   // line parser
   logic [6:0]  rx_ch;
   logic [3:0]  len_reg;
   logic        line_bad_reg;
   logic [6:0]  op0_reg;
   logic [6:0]  op1_reg;
   logic [6:0]  opt_reg;
   logic [1:0]  arg_st_reg;
   logic        neg_reg;
   logic [9:0]  int_reg;
   logic [3:0]  frac_reg;
   logic [12:0] arg_tenths;
   logic        line_busy;

   assign rx_ch     = rx_sh_reg[7:1];
   assign line_busy = (len_reg != 4'h0) || (rx_st_reg == SCP_RX_BITS);
   // further fractional digits were simply never stored
   assign arg_tenths = 13'(int_reg * 10) + 13'(frac_reg);

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         len_reg      <= '0;
         line_bad_reg <= 1'b0;
         op0_reg      <= CH_NONE;
         op1_reg      <= CH_NONE;
         opt_reg      <= CH_NONE;
         arg_st_reg   <= ARG_NONE;
         neg_reg      <= 1'b0;
         int_reg      <= '0;
         frac_reg     <= '0;
      end
      else if (rx_done_reg)
      begin
         if (rx_ch == CH_LF && !rx_bad_reg)
         begin
            len_reg      <= '0;
            line_bad_reg <= 1'b0;
            op0_reg      <= CH_NONE;
            op1_reg      <= CH_NONE;
            opt_reg      <= CH_NONE;
            arg_st_reg   <= ARG_NONE;
            neg_reg      <= 1'b0;
            int_reg      <= '0;
            frac_reg     <= '0;
         end
         else if (rx_bad_reg)
            line_bad_reg <= 1'b1;
         else if (rx_ch != CH_CR)
         begin
            if (len_reg != 4'hF)
               len_reg <= len_reg + 1'b1;
            if (len_reg == 4'h0)
               op0_reg <= rx_ch;
            // argument follows the letters directly
            else if (len_reg == 4'h1 && !is_digit(rx_ch) &&
                     rx_ch != CH_DOT && rx_ch != CH_MINUS)
               op1_reg <= rx_ch;
            else if (is_digit(rx_ch))
            begin
               if (arg_st_reg == ARG_FRAC)
               begin
                  frac_reg   <= rx_ch[3:0];
                  arg_st_reg <= ARG_DONE;
               end
               else if (arg_st_reg != ARG_DONE)
               begin
                  arg_st_reg <= ARG_INT;
                  if (int_reg > INT_MAX / 10'h00A)
                     int_reg <= INT_SAT;
                  else
                     int_reg <= 10'(int_reg * 10) + 10'(rx_ch[3:0]);
               end
            end
            else if (rx_ch == CH_DOT)
            begin
               if (arg_st_reg == ARG_NONE || arg_st_reg == ARG_INT)
                  arg_st_reg <= ARG_FRAC;
               else
                  line_bad_reg <= 1'b1;
            end
            else if (rx_ch == CH_MINUS && arg_st_reg == ARG_NONE)
               neg_reg <= 1'b1;
            else
               opt_reg <= rx_ch;
         end
      end
   end

   // command output
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cmd_valid   <= 1'b0;
         cmd_op0     <= CH_NONE;
         cmd_op1     <= CH_NONE;
         cmd_opt     <= CH_NONE;
         cmd_has_arg <= 1'b0;
         cmd_arg     <= '0;
         cmd_query   <= 1'b0;
         cmd_refused <= 1'b0;
         rx_err      <= 1'b0;
      end
      else
      begin
         cmd_valid   <= 1'b0;
         cmd_refused <= 1'b0;
         rx_err      <= rx_done_reg && rx_bad_reg;
         if (rx_done_reg && !rx_bad_reg && rx_ch == CH_LF &&
             len_reg != 4'h0 && !line_bad_reg)
         begin
            if (op0_reg == CAL_CMD)
               cmd_refused <= 1'b1;
            else
            begin
               // no case check; every first character but CAL_CMD is delivered as received
               cmd_valid   <= 1'b1;
               cmd_op0     <= op0_reg;
               cmd_op1     <= op1_reg;
               cmd_opt     <= opt_reg;
               cmd_has_arg <= (arg_st_reg != ARG_NONE);
               cmd_query   <= (op0_reg == CH_QUERY);
               if (neg_reg)
                  cmd_arg <= '0;
               else if (arg_tenths > TENTHS_MAX || int_reg > INT_MAX)
                  cmd_arg <= TENTHS_MAX;
               else
                  cmd_arg <= arg_tenths;
            end
         end
      end
   end

   // response path
   logic       fifo_ready;
   logic       q_valid;
   logic [7:0] q_data;
   logic       q_pop;
   logic       armed_reg;
   scp_tx_t    tx_st_reg;
   logic [3:0] tx_ovs_reg;
   logic [3:0] tx_bit_reg;
   logic [9:0] tx_sh_reg;
   logic       tx_last_reg;

   scp_fifo #(
      .W     (8),
      .DEPTH (RESP_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .srst      (srst),
      .in_valid  (resp_valid),
      .in_data   ({resp_last, resp_data}),
      .in_ready  (fifo_ready),
      .out_valid (q_valid),
      .out_data  (q_data),
      .out_ready (q_pop)
   );

   // text waits in the fifo until a query has armed the sender
   assign q_pop = (tx_st_reg == SCP_TX_IDLE) && q_valid && armed_reg &&
                  !line_busy && tick_reg;

   always_ff @(posedge clk)
   begin
      if (srst)
         resp_ready <= 1'b0;
      else
         resp_ready <= fifo_ready && !(resp_valid && resp_ready);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         armed_reg <= 1'b0;
      else if (cmd_valid && cmd_query)
         armed_reg <= 1'b1;
      else if (tx_st_reg == SCP_TX_LF)
         armed_reg <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         tx_st_reg   <= SCP_TX_IDLE;
         tx_ovs_reg  <= '0;
         tx_bit_reg  <= '0;
         tx_sh_reg   <= '1;
         tx_last_reg <= 1'b0;
         txd         <= 1'b1;
      end
      else
      begin
         case (tx_st_reg)
            SCP_TX_IDLE:
            begin
               txd <= 1'b1;
               if (q_pop)
               begin
                  tx_sh_reg   <= {1'b1, odd_par(q_data[6:0]),
                                  q_data[6:0], 1'b0};
                  tx_last_reg <= q_data[7];
                  tx_ovs_reg  <= '0;
                  tx_bit_reg  <= '0;
                  tx_st_reg   <= SCP_TX_BITS;
               end
            end
            SCP_TX_BITS:
            begin
               txd <= tx_sh_reg[0];
               if (tick_reg)
               begin
                  tx_ovs_reg <= tx_ovs_reg + 1'b1;
                  if (tx_ovs_reg == OVS_LAST)
                  begin
                     tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
                     tx_bit_reg <= tx_bit_reg + 1'b1;
                     if (tx_bit_reg == BIT_LAST)
                        tx_st_reg <= tx_last_reg ? SCP_TX_LF
                                                 : SCP_TX_IDLE;
                  end
               end
            end
            SCP_TX_LF:
            begin
               // closing line feed; waits for a tick so that its start
               // bit is as long as every other bit
               if (tick_reg)
               begin
                  tx_sh_reg   <= {1'b1, odd_par(CH_LF), CH_LF, 1'b0};
                  tx_last_reg <= 1'b0;
                  tx_ovs_reg  <= '0;
                  tx_bit_reg  <= '0;
                  tx_st_reg   <= SCP_TX_BITS;
               end
            end
            default:
               tx_st_reg <= SCP_TX_IDLE;
         endcase
      end
   end
endmodule

//--- scp_top_checker.sv
// concurrent checks on the serial command port top level
`timescale 1ns/1ps
module scp_top_checker
   import scp_pkg::*;
#(
   parameter int         TICK_CYCLES = TICK_DIV,
   parameter logic [6:0] CAL_CMD     = 7'h43
) (
   // clock and reset
   input wire logic        clk,
   input wire logic        srst,
   // serial link
   input wire logic        rxd,
   input wire logic        txd,
   // command and response
   input wire logic        cmd_valid,
   input wire logic [6:0]  cmd_op0,
   input wire logic [12:0] cmd_arg,
   input wire logic        cmd_query,
   input wire logic        cmd_refused,
   input wire logic        rx_err,
   input wire logic        resp_valid,
   input wire logic        resp_ready
);
   localparam int BITC = OVS * TICK_CYCLES;
   // a reply may start half a bit before the stop bit ends: guard nine bits
   localparam int RX_GUARD = 9 * BITC;
   int   rx_busy_reg;
   int   low_run_reg;
   logic rxd_q_reg;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   always_ff @(posedge clk)
      rxd_q_reg <= rxd;
   always_ff @(posedge clk)
      if (srst)
         rx_busy_reg <= 0;
      else if (rx_busy_reg != 0)
         rx_busy_reg <= rx_busy_reg - 1;
      else if (rxd_q_reg && !rxd)
         rx_busy_reg <= RX_GUARD;
   always_ff @(posedge clk)
      low_run_reg <= txd ? 0 : low_run_reg + 1;
   sequence s_push;
      resp_valid && resp_ready;
   endsequence
   sequence s_hold_off;
      !resp_ready;
   endsequence
   chk_reset_quiet:
   assert property ($fell(srst) |-> txd && !cmd_valid && !cmd_refused
      && !rx_err && !resp_ready) else $error("outputs busy after reset");
   chk_tx_bit_len:
   assert property ($rose(txd) |-> low_run_reg != 0
      && low_run_reg % BITC == 0) else $error("tx low run not whole bits");
   chk_tx_quiet_rx:
   assert property (rx_busy_reg != 0 |-> !$fell(txd))
      else $error("reply started during a received frame");
   chk_push_gap:
   assert property (s_push |=> s_hold_off)
      else $error("ready did not drop after a push");
   chk_cmd_pulse:
   assert property (cmd_valid |=> !cmd_valid)
      else $error("command strobe longer than one cycle");
   chk_arg_limit:
   assert property (cmd_valid |-> cmd_arg <= TENTHS_MAX)
      else $error("argument above the temperature limit");
   chk_query_flag:
   assert property (cmd_valid |-> cmd_query == (cmd_op0 == CH_QUERY))
      else $error("query flag disagrees with first letter");
   chk_cal_refused:
   assert property (cmd_valid |-> cmd_op0 != CAL_CMD)
      else $error("calibration entry delivered as a command");
   chk_err_alone:
   assert property (rx_err |-> !cmd_valid && !cmd_refused)
      else $error("bad character delivered with a command");
endmodule

bind scp_top scp_top_checker #(
   .TICK_CYCLES(TICK_CYCLES),
   .CAL_CMD    (CAL_CMD)
) u_scp_top_checker (
   .clk(clk), .srst(srst), .rxd(rxd), .txd(txd), .cmd_valid(cmd_valid),
   .cmd_op0(cmd_op0), .cmd_arg(cmd_arg), .cmd_query(cmd_query),
   .cmd_refused(cmd_refused), .rx_err(rx_err), .resp_valid(resp_valid),
   .resp_ready(resp_ready)
);

//--- scp_host_model.sv
// host serial port model: sends command lines, decodes reply frames
`timescale 1ns/1ps
module scp_host_model
   import scp_pkg::*;
#(
   parameter int BIT_CLKS = 64
) (
   // clock
   input  wire logic clk,
   // serial link
   output logic      rxd,
   input  wire logic txd
);
   event       got_ev;
   logic [6:0] got_ch;
   logic       got_bad;
   logic [8:0] sh;
   logic       st;
   initial
      rxd = 1'b1;
   task automatic bit_out(input logic b);
      rxd = b;
      repeat (BIT_CLKS) @(negedge clk);
   endtask
   // bad flips the parity bit so the device sees a damaged character
   task automatic send_char(input logic [6:0] ch, input logic bad);
      @(negedge clk);
      bit_out(1'b0);
      for (int i = 0; i < 7; i++)
         bit_out(ch[i]);
      bit_out(~^ch ^ bad);
      bit_out(1'b1);
   endtask
   task automatic send_line(input string s);
      for (int i = 0; i < s.len(); i++)
         send_char(7'(s[i]), 1'b0);
      send_char(CH_CR, 1'b0);
      send_char(CH_LF, 1'b0);
   endtask
   initial
   begin
      forever
      begin
         @(negedge txd);
         repeat (BIT_CLKS / 2) @(posedge clk);
         st = txd;
         for (int i = 0; i < 9; i++)
         begin
            repeat (BIT_CLKS) @(posedge clk);
            sh[i] = txd;
         end
         got_ch = sh[6:0];
         got_bad = st | ~(^sh[7:0]) | ~sh[8];
         -> got_ev;
      end
   end
endmodule

//--- scp_top_tb.sv
// self-checking bench for the serial command port
`timescale 1ns/1ps
module scp_top_tb
   import scp_pkg::*;
;
   localparam int TICK = 4;
   logic        clk, srst, rxd, txd, cmd_valid, cmd_has_arg, cmd_query;
   logic        cmd_refused, rx_err, resp_valid, resp_last, resp_ready;
   logic [6:0]  cmd_op0, cmd_op1, cmd_opt, resp_data;
   logic [12:0] cmd_arg;
   logic [23:0] exp_q[$];
   int          failures, total_checks, cycles, seed, v, f, e;
   string       s;

   scp_top #(.TICK_CYCLES(TICK)) u_scp_top (
      .clk(clk), .srst(srst), .rxd(rxd), .txd(txd), .cmd_valid(cmd_valid),
      .cmd_op0(cmd_op0), .cmd_op1(cmd_op1), .cmd_opt(cmd_opt),
      .cmd_has_arg(cmd_has_arg), .cmd_arg(cmd_arg), .cmd_query(cmd_query),
      .cmd_refused(cmd_refused), .rx_err(rx_err), .resp_valid(resp_valid),
      .resp_data(resp_data), .resp_last(resp_last), .resp_ready(resp_ready));
   scp_host_model #(.BIT_CLKS(OVS * TICK)) u_scp_host_model (
      .clk(clk), .rxd(rxd), .txd(txd));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic results();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [23:0] exp,
      input logic [23:0] got);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic take(input string what, input logic [23:0] got);
      if (exp_q.size() == 0)
         chk({what, " unexpected"}, 24'hFFFFFF, got);
      else
         chk(what, exp_q.pop_front(), got);
   endtask
   task automatic cmd(input string line, input logic [6:0] op,
      input logic ha, input logic [12:0] a);
      exp_q.push_back({2'h0, op, ha, a, op == CH_QUERY});
      u_scp_host_model.send_line(line);
      wait (exp_q.size() == 0);
   endtask
   task automatic push(input logic [6:0] ch, input logic last);
      @(negedge clk);
      resp_valid = 1'b1;
      resp_data = ch;
      resp_last = last;
      @(posedge clk);
      while (resp_ready !== 1'b1)
         @(posedge clk);
      @(negedge clk);
      resp_valid = 1'b0;
   endtask

   always @(posedge clk)
   begin
      if (!srst && cmd_valid === 1'b1)
         take("cmd", {2'h0, cmd_op0, cmd_has_arg,
            cmd_has_arg ? cmd_arg : 13'h0, cmd_query});
      if (!srst && cmd_refused === 1'b1)
         take("refused", 24'h400000);
      if (!srst && rx_err === 1'b1)
         take("rx_err", 24'h800000);
      cycles++;
      if (cycles >= 100000)
      begin
         failures++;
         results();
      end
   end
   always @(u_scp_host_model.got_ev)
      take("tx", {2'h3, u_scp_host_model.got_ch,
         u_scp_host_model.got_bad, 14'h0});

   initial
   begin
      seed = 86;
      srst = 1'b1;
      resp_valid = 1'b0;
      resp_data = 7'h00;
      resp_last = 1'b0;
      repeat (10) @(negedge clk);
      srst = 1'b0;
      repeat (2) @(negedge clk);
      // text pushed before any query must wait in the buffer
      for (int i = 0; i < 16; i++)
         push(7'h30 + 7'(i % 10), i == 15);
      repeat (4) @(negedge clk);
      chk("ready full", 24'h0, {23'h0, resp_ready});
      cmd("H300", 7'h48, 1'b1, 13'd3000);
      cmd("L31.2", 7'h4C, 1'b1, 13'd312);
      cmd("L.5", 7'h4C, 1'b1, 13'd5);
      cmd("H12.39", 7'h48, 1'b1, 13'd123);
      cmd("H475.9", 7'h48, 1'b1, 13'd4750);
      cmd("R", 7'h52, 1'b0, 13'd0);
      for (int k = 0; k < 3; k++)
      begin
         v = {$random(seed)} % 600;
         f = {$random(seed)} % 100;
         e = v * 10 + f / 10;
         if (e > 4750)
            e = 4750;
         s = $sformatf("L%0d.%02d", v, f);
         cmd(s, 7'h4C, 1'b1, 13'(e));
      end
      cmd("H1030", 7'h48, 1'b1, 13'd4750);
      cmd("L-5", 7'h4C, 1'b1, 13'd0);
      u_scp_host_model.send_line("H1..5");
      cmd("F0K", 7'h46, 1'b1, 13'd0);
      chk("opt", {17'h0, 7'h4B}, {17'h0, cmd_opt});
      chk("op1 none", 24'h0, {17'h0, cmd_op1});
      u_scp_host_model.send_line("");
      exp_q.push_back(24'h400000);
      u_scp_host_model.send_line("C5");
      wait (exp_q.size() == 0);
      exp_q.push_back(24'h800000);
      u_scp_host_model.send_char(7'h48, 1'b1);
      u_scp_host_model.send_line("5");
      cmd("H20", 7'h48, 1'b1, 13'd200);
      exp_q.push_back({2'h0, CH_QUERY, 1'b0, 13'h0, 1'b1});
      for (int i = 0; i < 16; i++)
         exp_q.push_back({2'h3, 7'h30 + 7'(i % 10), 15'h0});
      exp_q.push_back({2'h3, CH_LF, 15'h0});
      u_scp_host_model.send_line("WS");
      wait (exp_q.size() == 0);
      @(negedge clk);
      chk("ready drained", 24'h1, {23'h0, resp_ready});
      chk("op1", {17'h0, 7'h53}, {17'h0, cmd_op1});
      results();
   end
endmodule
